// [hw/caf_core.sv]
`timescale 1ns/1ps
`default_nettype none
module caf_core (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        init_mode_acknowledge_in,
  input  wire logic        sleep_acknowledge_in,
  input  wire logic        frame_valid_in,
  input  wire logic [31:0] received_identifier_bytes_in,
  input  wire logic        frame_extended_in,
  input  wire logic        fg_shift_in,
  input  wire logic        bus_off_in,
  input  wire logic [7:0]  rx_fault_count_in,
  input  wire logic [7:0]  tx_fault_count_in,
  output logic             init_mode_request_out,
  output logic             sleep_request_out,
  output logic [1:0]       filter_organization_mode_out,
  output logic             recovery_request_out,
  output logic             bus_off_hold_out,
  output logic [31:0]      bg_identifier_out,
  output logic             frame_accept_out,
  output logic [2:0]       filter_hit_index_out,
  output logic             irq_out
);
  logic [7:0]  code_q [8];
  logic [7:0]  mask_q [8];
  logic [4:0]  ctrl_q;
  logic        hold_q;
  logic [2:0]  irq_st_q;
  logic [2:0]  irq_en_q;
  logic [2:0]  hit_pend_q;
  logic [2:0]  hit_q;
  logic [31:0] bg_q;
  logic        acc_q;
  logic        busoff_q;
  logic        rec_q;
  logic        rd_ack_q;
  logic [31:0] rdata_q;
  logic        wr_en;
  logic        in_init;
  logic        in_sleep;
  logic        accept;
  logic [2:0]  hit_idx;
  logic [2:0]  ev;

  assign in_init  = ctrl_q[caf_pkg::CTRL_INIT_MODE_REQUEST] & init_mode_acknowledge_in;
  assign in_sleep = ctrl_q[caf_pkg::CTRL_SLEEP_REQUEST] & sleep_acknowledge_in;
  // writes done in one cycle; reads take a registered cycle
  assign wr_en = avs_write_in & avs_byteenable_in[0];
  assign avs_waitrequest_out = avs_read_in & ~rd_ack_q;

  // bit-by-bit match of one identifier byte under its mask
  function automatic logic byte_ok(input logic [7:0] id, input logic [7:0] c,
                                   input logic [7:0] m);
    byte_ok = &((~(id ^ c)) | m); // RULE_10 RULE_11
  endfunction

  always_comb begin
    logic [7:0] hits;
    logic [7:0] b [4];
    hits = 8'h00;
    for (int k = 0; k < 4; k++) begin
      b[k] = received_identifier_bytes_in[31-8*k -: 8]; // RULE_08
    end
    unique case (ctrl_q[1:0])
      caf_pkg::MODE_32: begin
        for (int f = 0; f < 2; f++) begin
          hits[f] = byte_ok(b[0], code_q[4*f], mask_q[4*f]) // RULE_17
                  & byte_ok(b[1], code_q[4*f+1], mask_q[4*f+1])
                  & (~frame_extended_in // RULE_09
                     | (byte_ok(b[2], code_q[4*f+2], mask_q[4*f+2])
                      & byte_ok(b[3], code_q[4*f+3], mask_q[4*f+3])));
        end
      end
      caf_pkg::MODE_16: begin
        for (int f = 0; f < 4; f++) begin
          hits[f] = byte_ok(b[0], code_q[2*f], mask_q[2*f])
                  & byte_ok(b[1], code_q[2*f+1], mask_q[2*f+1]);
        end
      end
      caf_pkg::MODE_8: begin
        for (int f = 0; f < 8; f++) begin
          hits[f] = byte_ok(b[0], code_q[f], mask_q[f]);
        end
      end
      caf_pkg::MODE_CLS: hits = 8'h00; // RULE_15
    endcase
    accept = |hits;
    hit_idx = 3'h0;
    for (int f = 7; f >= 0; f--) begin
      if (hits[f]) begin
        hit_idx = 3'(f); // RULE_18
      end
    end
  end

  // background buffer always loads; a rejected frame just waits to be overwritten
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bg_q <= 32'h0000_0000;
      acc_q <= 1'b0;
      hit_pend_q <= 3'h0;
    end else if (frame_valid_in) begin
      bg_q <= received_identifier_bytes_in; // RULE_06 RULE_07
      acc_q <= accept; // RULE_06
      hit_pend_q <= hit_idx;
    end else begin
      acc_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hit_q <= 3'h0;
    end else if (fg_shift_in) begin
      hit_q <= hit_pend_q; // RULE_16
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 8; i++) begin
        code_q[i] <= caf_pkg::RST_BYTE;
        mask_q[i] <= caf_pkg::RST_BYTE;
      end
    end else if (wr_en && in_init && avs_address_in[7:6] == 2'h0) begin
      if (avs_address_in[5]) begin // RULE_12
        mask_q[avs_address_in[4:2]] <= avs_writedata_in[7:0];
      end else begin
        code_q[avs_address_in[4:2]] <= avs_writedata_in[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= 5'h00;
      irq_en_q <= 3'h0;
    end else if (wr_en && avs_address_in == caf_pkg::ADR_CTRL) begin
      ctrl_q <= avs_writedata_in[4:0];
    end else if (wr_en && avs_address_in == caf_pkg::ADR_IRQ_EN) begin
      irq_en_q <= avs_writedata_in[2:0];
    end
  end

  // hold flag: set wins over a same-cycle software clear
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_q <= 1'b0;
      busoff_q <= 1'b0;
      rec_q <= 1'b0;
    end else begin
      busoff_q <= bus_off_in;
      rec_q <= 1'b0;
      if (bus_off_in && !busoff_q && ctrl_q[caf_pkg::CTRL_BORSEL]) begin
        hold_q <= 1'b1; // RULE_01
      end else if (wr_en && avs_address_in == caf_pkg::ADR_HOLD
                   && avs_writedata_in[0] && hold_q) begin
        hold_q <= 1'b0; // RULE_02
        rec_q <= 1'b1; // RULE_03
      end
    end
  end

  // events: bus-off entry, dropped frame, accepted frame
  assign ev = {bus_off_in & ~busoff_q,
               frame_valid_in & ~accept,
               frame_valid_in & accept};

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_st_q <= 3'h0;
    end else if (wr_en && avs_address_in == caf_pkg::ADR_IRQ_CLR) begin
      irq_st_q <= (irq_st_q & ~avs_writedata_in[2:0]) | ev;
    end else begin
      irq_st_q <= irq_st_q | ev;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rd_ack_q <= avs_read_in & ~rd_ack_q;
      rdata_q <= 32'h0000_0000;
      if (avs_address_in[7:6] == 2'h0) begin
        rdata_q[7:0] <= avs_address_in[5] ? mask_q[avs_address_in[4:2]]
                                          : code_q[avs_address_in[4:2]];
      end else begin
        unique case (avs_address_in)
          caf_pkg::ADR_CTRL:   rdata_q[4:0] <= ctrl_q;
          caf_pkg::ADR_HOLD:   rdata_q[0] <= hold_q;
          caf_pkg::ADR_RXERR:  rdata_q[7:0] <= (in_sleep | in_init)
                                 ? rx_fault_count_in : 8'h00; // RULE_04
          caf_pkg::ADR_TXERR:  rdata_q[7:0] <= (in_sleep | in_init)
                                 ? tx_fault_count_in : 8'h00; // RULE_04
          caf_pkg::ADR_STAT:   rdata_q[3:0] <= {init_mode_acknowledge_in,
                                                hit_q};
          caf_pkg::ADR_IRQ_ST: rdata_q[2:0] <= irq_st_q;
          caf_pkg::ADR_IRQ_EN: rdata_q[2:0] <= irq_en_q;
          default:             rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata_out = rdata_q;
  assign init_mode_request_out = ctrl_q[caf_pkg::CTRL_INIT_MODE_REQUEST];
  assign sleep_request_out = ctrl_q[caf_pkg::CTRL_SLEEP_REQUEST];
  assign filter_organization_mode_out = ctrl_q[1:0];
  assign recovery_request_out = rec_q;
  assign bus_off_hold_out = hold_q; // RULE_01
  assign bg_identifier_out = bg_q;
  assign frame_accept_out = acc_q;
  assign filter_hit_index_out = hit_q;
  assign irq_out = |(irq_st_q & irq_en_q);

  property p_hold_set;
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (bus_off_in && !busoff_q && ctrl_q[caf_pkg::CTRL_BORSEL]) |=> hold_q;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("hold not set"); // RULE_01
  property p_hold_clr;
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (wr_en && avs_address_in == caf_pkg::ADR_HOLD && avs_writedata_in[0]
     && hold_q && !(bus_off_in && !busoff_q)) |=> !hold_q && rec_q;
  endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("hold not cleared"); // RULE_02
  property p_code_lock;
    @(posedge core_clk_in) disable iff (!arst_n_in)
    !in_init |=> $stable(code_q[0]) && $stable(mask_q[0]);
  endproperty
  a_code_lock: assert property (p_code_lock) else $error("filter written"); // RULE_12
  property p_closed;
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (frame_valid_in && ctrl_q[1:0] == caf_pkg::MODE_CLS) |=> !acc_q;
  endproperty
  a_closed: assert property (p_closed) else $error("closed accepted"); // RULE_15
  property p_hit;
    @(posedge core_clk_in) disable iff (!arst_n_in)
    fg_shift_in |=> hit_q == $past(hit_pend_q);
  endproperty
  a_hit: assert property (p_hit) else $error("hit not updated"); // RULE_16
  property p_store;
    @(posedge core_clk_in) disable iff (!arst_n_in)
    frame_valid_in |=> bg_q == $past(received_identifier_bytes_in);
  endproperty
  a_store: assert property (p_store) else $error("frame not stored"); // RULE_06
  property p_mask_all;
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (ctrl_q[1:0] == caf_pkg::MODE_8 && mask_q[0] == 8'hFF) |-> accept && hit_idx == 3'h0;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("mask ignored"); // RULE_11
  property p_err_hide;
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (avs_read_in && !rd_ack_q && avs_address_in == caf_pkg::ADR_RXERR
     && !in_init && !in_sleep) |=> avs_readdata_out == 32'h0000_0000;
  endproperty
  a_err_hide: assert property (p_err_hide) else $error("count leaked"); // RULE_04
endmodule
`default_nettype wire

// [hw/caf_pkg.sv]
// Contract
// [RULE_01] with hold option on, bus-off sets hold flag; stays bus-off until software requests
// [RULE_02] writing one clears the hold flag; zero ignored; writes accepted any time
// [RULE_03] clearing the hold flag requests bus-off recovery
// [RULE_04] error counters read-only, valid only in sleep or init mode
// [RULE_05] software reads error counters only in sleep or init mode
// [RULE_06] every frame stored in background buffer; cpu signalled only if accepted; a rejected frame also sets IRQ_DROP, raising irq_out when enabled
// [RULE_07] rejected frame is overwritten by the next received frame
// [RULE_08] code and mask bits apply bit by bit to identifier bytes
// [RULE_09] extended frames use four byte pairs, standard frames first two
// [RULE_10] compare code bit with identifier bit, then qualify with mask bit
// [RULE_11] mask zero needs equality, mask one excludes; accept when all match
// [RULE_12] code and mask readable always, writable only in init mode
// [RULE_13] 32-bit mode standard frames need mask byte 1 and 5 low bits don't-care
// [RULE_14] 16-bit mode standard frames need odd mask bytes low bits don't-care
// [RULE_15] mode field: 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed
// [RULE_16] hit index names filter of foreground frame, updated on each move
// [RULE_17] filters use consecutive byte groups: four, two or one bytes
// [RULE_18] several hits report the lowest-numbered filter
package caf_pkg;
  localparam logic [5:0] OFS_CODE0   = 6'h00; // code bytes at 00..1C
  localparam logic [5:0] OFS_MASK0   = 6'h20; // mask bytes at 20..3C
  localparam logic [7:0] ADR_CTRL    = 8'h40;
  localparam logic [7:0] ADR_HOLD    = 8'h44;
  localparam logic [7:0] ADR_RXERR   = 8'h48;
  localparam logic [7:0] ADR_TXERR   = 8'h4C;
  localparam logic [7:0] ADR_STAT    = 8'h50;
  localparam logic [7:0] ADR_IRQ_ST  = 8'h54;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h58;
  localparam logic [7:0] ADR_IRQ_EN  = 8'h5C;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INIT_MODE_REQUEST   = 2;
  localparam int CTRL_SLEEP_REQUEST    = 3;
  localparam int CTRL_BORSEL   = 4;
  localparam int IRQ_ACCEPT    = 0;
  localparam int IRQ_DROP      = 1;
  localparam int IRQ_BUSOFF    = 2;
  localparam logic [1:0] MODE_32  = 2'h0;
  localparam logic [1:0] MODE_16  = 2'h1;
  localparam logic [1:0] MODE_8   = 2'h2;
  localparam logic [1:0] MODE_CLS = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// [test/caf_engine_model.sv]
`timescale 1ns/1ps
`default_nettype none
module caf_engine_model (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        init_req_in,
  input  wire logic        sleep_req_in,
  input  wire logic        recovery_in,
  input  wire logic [3:0]  lag_in,
  output logic             init_ack_out,
  output logic             sleep_ack_out,
  output logic             valid_out,
  output logic [31:0]      ident_out,
  output logic             ext_out,
  output logic             shift_out,
  output logic             bus_off_out
);
  logic [3:0] n_q;
  initial {valid_out, ident_out, ext_out, shift_out, bus_off_out} = '0;
  // acks follow only every lag_in+1 cycles, so slow engines get covered
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      n_q <= 4'h0;
      {init_ack_out, sleep_ack_out} <= 2'h0;
    end else if (n_q < lag_in) begin
      n_q <= n_q + 4'h1;
    end else begin
      n_q <= 4'h0;
      {init_ack_out, sleep_ack_out} <= {init_req_in, sleep_req_in};
    end
  end
  // bus-off stands until the controller asks for recovery
  always @(posedge clk_in) begin
    if (recovery_in) begin
      bus_off_out <= 1'b0;
    end
  end
  task automatic send(input logic [31:0] id, input logic ext);
    valid_out <= 1'b1;
    ident_out <= id;
    ext_out   <= ext;
    @(posedge clk_in);
    valid_out <= 1'b0;
    ident_out <= ~id; // no stale identifier after the frame
    ext_out   <= ~ext;
  endtask
  task automatic shift();
    shift_out <= 1'b1;
    @(posedge clk_in);
    shift_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/can_accept_filter_err_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module can_accept_filter_err_status_tb;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0]  adr = 8'h00, rxc = 8'h00, txc = 8'h00, q;
  logic [31:0] wd = 32'h0, rdat, bgid, id, idw;
  logic        wt, irq, acc, hold, rec, ireq, sreq, iack, sack;
  logic        fv, fx, shf, boff, ext, sa, sd;
  logic [1:0]  mode;
  logic [2:0]  hit;
  logic [3:0]  lag = 4'h0, e;
  logic [7:0]  code[8] = '{default: 8'h00}, mask[8];
  int          miscompares = 0, checks_done = 0, seed = 74, rec_n = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (rec === 1'b1) rec_n++;
  caf_core u_dut (.core_clk_in(clk), .arst_n_in(rst_n),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .init_mode_acknowledge_in(iack), .sleep_acknowledge_in(sack),
    .frame_valid_in(fv), .received_identifier_bytes_in(idw),
    .frame_extended_in(fx), .fg_shift_in(shf), .bus_off_in(boff),
    .rx_fault_count_in(rxc), .tx_fault_count_in(txc),
    .init_mode_request_out(ireq), .sleep_request_out(sreq),
    .filter_organization_mode_out(mode), .recovery_request_out(rec),
    .bus_off_hold_out(hold), .bg_identifier_out(bgid),
    .frame_accept_out(acc), .filter_hit_index_out(hit), .irq_out(irq));
  caf_engine_model u_eng (.clk_in(clk), .arst_n_in(rst_n),
    .init_req_in(ireq), .sleep_req_in(sreq), .recovery_in(rec),
    .lag_in(lag), .init_ack_out(iack), .sleep_ack_out(sack),
    .valid_out(fv), .ident_out(idw), .ext_out(fx), .shift_out(shf),
    .bus_off_out(boff));
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 60) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    adr <= a;
    wd  <= {24'h0, d};
    wr  <= w;
    rd  <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 60);
    q = rdat[7:0];
    guard(n);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk(32'(q), 32'(x));
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    guard(n);
  endtask
  task automatic ctrl(input logic [7:0] v);
    bus(1'b1, caf_pkg::ADR_CTRL, v);
    wait_for(iack, v[2]);
    wait_for(sack, v[3]);
  endtask
  // lowest filter wins, so scan downwards
  function automatic logic [3:0] hit_of(input logic [31:0] v, input logic x,
                                        input logic [1:0] m);
    int nf;
    int k;
    logic ok;
    logic [3:0] r;
    nf = (m == 2'h3) ? 0 : 2 << m;
    r = 4'h0;
    for (int f = nf - 1; f >= 0; f--) begin
      ok = 1'b1;
      for (int b = 0; b < 8 / nf; b++) begin
        k = f * 8 / nf + b;
        if (x || b < 2) ok = ok && ((v[31 - 8 * b -: 8] ^ code[k])
          & ~mask[k]) == 8'h00;
      end
      if (ok) r = {1'b1, 3'(f)};
    end
    return r;
  endfunction
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int m = 0; m < 4; m++) begin
      lag <= 4'($random(seed) & 7);
      bus(1'b1, 8'h00, ~code[0]);
      rdchk(8'h00, code[0]);
      rxc <= 8'($random(seed));
      txc <= 8'($random(seed));
      ctrl(8'h04 | 8'(m));
      for (int i = 0; i < 8; i++) begin
        code[i] = 8'($random(seed));
        mask[i] = 8'($random(seed) | $random(seed));
        if (m < 2 && i[0]) mask[i] = mask[i] | 8'h07;
        bus(1'b1, 8'(4 * i), code[i]);
        bus(1'b1, {2'h0, caf_pkg::OFS_MASK0} + 8'(4 * i), mask[i]);
        rdchk(8'(4 * i), code[i]);
        rdchk({2'h0, caf_pkg::OFS_MASK0} + 8'(4 * i), mask[i]);
      end
      rdchk(caf_pkg::ADR_RXERR, rxc);
      bus(1'b1, caf_pkg::ADR_TXERR, ~txc);
      rdchk(caf_pkg::ADR_TXERR, txc);
      ctrl(8'(m));
      chk(32'(mode), 32'(m));
      rdchk(caf_pkg::ADR_RXERR, 8'h00);
      bus(1'b1, caf_pkg::ADR_IRQ_CLR, 8'h07);
      bus(1'b1, caf_pkg::ADR_IRQ_EN, (m == 3) ? 8'h01 : 8'h03);
      sa = 1'b0;
      sd = 1'b0;
      for (int i = 0; i < 10; i++) begin
        id = $random(seed);
        if (i[0]) id = {code[4], code[5], code[6], code[7]};
        ext = 1'($random(seed));
        e = hit_of(id, ext, 2'(m));
        u_eng.send(id, ext);
        @(negedge clk);
        chk(32'(acc), 32'(e[3]));
        chk(bgid, id);
        sa = sa | e[3];
        sd = sd | !e[3];
        if (e[3]) begin
          @(posedge clk);
          u_eng.shift();
          @(negedge clk);
          chk(32'(hit), 32'(e[2:0]));
        end
        @(posedge clk);
      end
      chk(32'(irq), 32'(sa | (sd & (m != 3))));
      rdchk(caf_pkg::ADR_IRQ_ST, {6'h0, sd, sa});
      bus(1'b1, caf_pkg::ADR_IRQ_CLR, 8'h07);
      chk(32'(irq), 32'h0);
    end
    ctrl(8'h08);
    rdchk(caf_pkg::ADR_TXERR, txc);
    ctrl(8'h10);
    u_eng.bus_off_out <= 1'b1;
    wait_for(hold, 1'b1);
    rdchk(caf_pkg::ADR_HOLD, 8'h01);
    rdchk(caf_pkg::ADR_IRQ_ST, 8'h04);
    bus(1'b1, caf_pkg::ADR_HOLD, 8'h00);
    rdchk(caf_pkg::ADR_HOLD, 8'h01);
    chk(rec_n, 0);
    bus(1'b1, caf_pkg::ADR_HOLD, 8'h01);
    rdchk(caf_pkg::ADR_HOLD, 8'h00);
    chk(rec_n, 1);
    test_done();
  end
endmodule
`default_nettype wire
